//--- hw/rsp_serial_port.sv
`timescale 1ns/1ps
`include "rsp_defines.svh"
// Summary of operation
// R1: Answer only requests carrying own unit address, range 01 to 31.
// R2: Address 00 disables all communication; bus never driven. Code gates only the RS-485 port; the loader port stays active.
// R3: Address is units switch plus group offset switch; defaults 1 and +0.
// R4: Master must keep slave addresses unique on one line.
// R5: Main port rates 2400 to 38400; default 9600.
// R6: New rate takes effect only after next power-on. Code resets ctrl at the same reset, so the captured rate is always 9600.
// R7: At power-on blink the rate LED for 5 s at 1 s intervals.
// R8: Loader port fixed at 9600 bps.
// R9: Parity bit sent and checked when enabled; none by default.
// R10: Even or odd parity counts ones over data plus parity.
// R11: One or two stop bits; two by default.
// R12: Reply waits the response delay, 5 to 99 ms, default 20.
// R13: Start bit, eight data bits LSB first, parity, stop bits.
// R14: Frames with parity, framing or check errors get no reply.
module rsp_serial_port (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] address_units_switch,
  input wire logic [1:0] address_group_switch,
  input wire logic rs485_rx,
  output logic rs485_tx,
  output logic rs485_de,
  input wire logic loader_rx,
  output logic loader_tx,
  output logic [3:0] rate_led,
  output logic irq,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import rsp_pkg::*;
  localparam int unsigned MS_CYC = `RSP_MS_CYCLES;
  localparam logic [15:0] LDR_DIV = 16'((`RSP_CLK_HZ + `RSP_LOADER_BAUD / 2) / `RSP_LOADER_BAUD - 1);
  logic [31:0] ctrl_q;
  logic [5:0] stat_q, mask_q;
  rsp_rate_type rate_q;
  logic [5:0] addr_q;
  logic [7:0] txd_q, ldr_txd_q, rxd_q, ldr_rxd_q;
  logic tx_go_q, ldr_go_q;
  logic [15:0] div_q;
  logic [5:0] ev;
  logic tx_busy, tx_done, tx_line, rx_valid, rx_perr, rx_ferr;
  logic ldr_busy, ldr_done, ldr_line, ldr_valid, ldr_perr, ldr_ferr;
  logic [7:0] rx_byte, ldr_byte;
  logic boot_q;
  // Power-on capture of rate and address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      boot_q <= 1'b1;
      rate_q <= RSP_B9600;
      addr_q <= 6'h00;
      div_q <= 16'h0000;
    end else if (boot_q) begin
      boot_q <= 1'b0;
      rate_q <= rsp_rate_type'(ctrl_q[`RSP_CTRL_RATE_LSB +: 3]); // R6
      addr_q <= {address_group_switch, 4'h0} + {2'h0, address_units_switch}; // R3
      case (rsp_rate_type'(ctrl_q[`RSP_CTRL_RATE_LSB +: 3]))
        RSP_B2400: div_q <= 16'(`RSP_CLK_HZ / 2400 - 1); // R5
        RSP_B4800: div_q <= 16'(`RSP_CLK_HZ / 4800 - 1);
        RSP_B19200: div_q <= 16'(`RSP_CLK_HZ / 19200 - 1);
        RSP_B38400: div_q <= 16'(`RSP_CLK_HZ / 38400 - 1);
        default: div_q <= 16'(`RSP_CLK_HZ / 9600 - 1);
      endcase
    end
  end
  wire addr_ok = (addr_q != 6'h00) && (addr_q <= 6'(`RSP_ADDR_MAX)); // R1 R2
  rsp_par_type par;
  assign par = rsp_par_type'(ctrl_q[`RSP_CTRL_PAR_LSB +: 2]);
  rsp_uart_lane u_main (
    .aclk(aclk), .aresetn(aresetn), .bit_div(div_q), .par(par), .stop2(ctrl_q[`RSP_CTRL_STOP2_BIT]),
    .tx_go(tx_go_q), .tx_byte(txd_q), .tx_busy(tx_busy), .tx_done(tx_done), .tx_line(tx_line),
    .rx_line(rs485_rx | !addr_ok), .rx_valid(rx_valid), .rx_byte(rx_byte), .rx_perr(rx_perr), .rx_ferr(rx_ferr)
  );
  rsp_uart_lane u_loader (
    .aclk(aclk), .aresetn(aresetn), .bit_div(LDR_DIV), .par(RSP_PAR_NONE), .stop2(1'b0), // R8
    .tx_go(ldr_go_q), .tx_byte(ldr_txd_q), .tx_busy(ldr_busy), .tx_done(ldr_done), .tx_line(ldr_line),
    .rx_line(loader_rx), .rx_valid(ldr_valid), .rx_byte(ldr_byte), .rx_perr(ldr_perr), .rx_ferr(ldr_ferr)
  );
  // Request verdict and response delay
  logic armed_q;
  logic [6:0] wait_ms_q;
  logic [15:0] ms_cnt_q;
  wire [6:0] wait_cfg = ctrl_q[`RSP_CTRL_WAIT_LSB +: 7];
  wire [6:0] wait_lim = (wait_cfg < 7'(`RSP_WAIT_MIN_MS)) ? 7'(`RSP_WAIT_MIN_MS) :
                        (wait_cfg > 7'(`RSP_WAIT_MAX_MS)) ? 7'(`RSP_WAIT_MAX_MS) : wait_cfg;
  logic bad_q;
  wire req_ok, req_bad, aw_take, w_take;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bad_q <= 1'b0;
    end else if (rx_valid && (rx_perr || rx_ferr)) begin
      bad_q <= 1'b1; // R14
    end else if (req_ok || req_bad) begin
      bad_q <= 1'b0;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      armed_q <= 1'b0;
      wait_ms_q <= 7'h00;
      ms_cnt_q <= 16'h0000;
    end else if (req_ok && !bad_q && addr_ok) begin
      armed_q <= 1'b1; // R12
      wait_ms_q <= wait_lim;
      ms_cnt_q <= 16'(MS_CYC - 1);
    end else if (req_bad) begin
      armed_q <= 1'b0; // R14
    end else if (armed_q && wait_ms_q != 7'h00) begin
      if (ms_cnt_q == 16'h0000) begin
        ms_cnt_q <= 16'(MS_CYC - 1);
        wait_ms_q <= wait_ms_q - 7'h01;
      end else begin
        ms_cnt_q <= ms_cnt_q - 16'h0001;
      end
    end
  end
  wire may_send = armed_q && (wait_ms_q == 7'h00) && addr_ok; // R12 R2
  // Driver enable and line outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rs485_tx <= 1'b1;
      rs485_de <= 1'b0;
      loader_tx <= 1'b1;
    end else begin
      rs485_tx <= tx_line | !addr_ok;
      rs485_de <= tx_busy && addr_ok; // R2
      loader_tx <= ldr_line;
    end
  end
  // Power-on rate LED blink
  logic [9:0] led_ms_q;
  logic [15:0] led_cyc_q;
  logic [3:0] led_s_q;
  logic led_on_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      led_ms_q <= 10'h000;
      led_cyc_q <= 16'h0000;
      led_s_q <= 4'h0;
      led_on_q <= 1'b1;
      rate_led <= 4'h0;
    end else begin
      if (led_s_q < 4'(`RSP_LED_TIME_S)) begin
        if (led_cyc_q == 16'(MS_CYC - 1)) begin
          led_cyc_q <= 16'h0000;
          if (led_ms_q == 10'(`RSP_LED_PERIOD_MS / 2 - 1)) begin
            led_ms_q <= 10'h000;
            led_on_q <= !led_on_q;
            if (!led_on_q) begin
              led_s_q <= led_s_q + 4'h1;
            end
          end else begin
            led_ms_q <= led_ms_q + 10'h001;
          end
        end else begin
          led_cyc_q <= led_cyc_q + 16'h0001;
        end
      end
      rate_led <= 4'h0;
      if (!boot_q && led_s_q < 4'(`RSP_LED_TIME_S) && led_on_q) begin
        case (rate_q)
          RSP_B4800: rate_led <= 4'h1; // R7
          RSP_B9600: rate_led <= 4'h2;
          RSP_B19200: rate_led <= 4'h4;
          RSP_B38400: rate_led <= 4'h8;
          default: rate_led <= 4'h0;
        endcase
      end
    end
  end
  // AXI4-Lite write channel
  logic aw_hold_q, w_hold_q;
  logic [7:0] waddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  wire do_wr = aw_hold_q && w_hold_q && !s_axi_bvalid;
  wire [31:0] wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  assign req_ok = do_wr && waddr_q == `RSP_OFF_CTRL && wstrb_q[2] && wdata_q[`RSP_CTRL_REQ_OK_BIT];
  assign req_bad = do_wr && waddr_q == `RSP_OFF_CTRL && wstrb_q[2] && wdata_q[`RSP_CTRL_REQ_BAD_BIT];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      waddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      s_axi_awready <= !aw_hold_q && !aw_take && !s_axi_bvalid;
      s_axi_wready <= !w_hold_q && !w_take && !s_axi_bvalid;
      if (aw_take) begin
        aw_hold_q <= 1'b1;
        waddr_q <= s_axi_awaddr;
      end
      if (w_take) begin
        w_hold_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (waddr_q[1:0] == 2'h0 && waddr_q <= `RSP_OFF_INFO) ? 2'h0 : 2'h2;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  // Registers and interrupt status
  assign ev = {ldr_done, ldr_valid, rx_valid && rx_ferr, rx_valid && rx_perr, tx_done, rx_valid && !rx_perr && !rx_ferr};
  always_ff @(posedge aclk) begin
    tx_go_q <= 1'b0;
    ldr_go_q <= 1'b0;
    if (!aresetn) begin
      ctrl_q <= `RSP_CTRL_RESET;
      stat_q <= 6'h00;
      mask_q <= 6'h00;
      txd_q <= 8'h00;
      ldr_txd_q <= 8'h00;
      rxd_q <= 8'h00;
      ldr_rxd_q <= 8'h00;
      irq <= 1'b0;
    end else begin
      if (rx_valid) begin
        rxd_q <= rx_byte;
      end
      if (ldr_valid) begin
        ldr_rxd_q <= ldr_byte;
      end
      if (do_wr && waddr_q == `RSP_OFF_CTRL) begin
        ctrl_q <= ((ctrl_q & ~wmask) | (wdata_q & wmask)) & 32'h0000_7f77;
      end
      if (do_wr && waddr_q == `RSP_OFF_MASK && wstrb_q[0]) begin
        mask_q <= wdata_q[5:0];
      end
      if (do_wr && waddr_q == `RSP_OFF_TXD && wstrb_q[0] && may_send && !tx_busy) begin
        txd_q <= wdata_q[7:0];
        tx_go_q <= 1'b1; // R12
      end
      if (do_wr && waddr_q == `RSP_OFF_LDR_TXD && wstrb_q[0] && !ldr_busy) begin
        ldr_txd_q <= wdata_q[7:0];
        ldr_go_q <= 1'b1;
      end
      if (do_wr && waddr_q == `RSP_OFF_STAT && wstrb_q[0]) begin
        stat_q <= (stat_q & ~wdata_q[5:0]) | ev;
      end else begin
        stat_q <= stat_q | ev;
      end
      irq <= |(stat_q & mask_q);
    end
  end
  // AXI4-Lite read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'h0;
        if (s_axi_araddr == `RSP_OFF_CTRL) begin
          s_axi_rdata <= ctrl_q;
        end else if (s_axi_araddr == `RSP_OFF_STAT) begin
          s_axi_rdata <= {26'h0, stat_q};
        end else if (s_axi_araddr == `RSP_OFF_MASK) begin
          s_axi_rdata <= {26'h0, mask_q};
        end else if (s_axi_araddr == `RSP_OFF_TXD) begin
          s_axi_rdata <= {22'h0, may_send, tx_busy, txd_q};
        end else if (s_axi_araddr == `RSP_OFF_RXD) begin
          s_axi_rdata <= {24'h0, rxd_q};
        end else if (s_axi_araddr == `RSP_OFF_LDR_TXD) begin
          s_axi_rdata <= {23'h0, ldr_busy, ldr_txd_q};
        end else if (s_axi_araddr == `RSP_OFF_LDR_RXD) begin
          s_axi_rdata <= {24'h0, ldr_rxd_q};
        end else if (s_axi_araddr == `RSP_OFF_INFO) begin
          s_axi_rdata <= {20'h0, armed_q, addr_ok, rate_q, 2'h0, addr_q[4:0]};
        end else begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= 2'h2;
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule

//--- hw/rsp_defines.svh
`ifndef RSP_DEFINES_SVH
`define RSP_DEFINES_SVH
`define RSP_CLK_HZ 25000000
`define RSP_OFF_CTRL 8'h00
`define RSP_OFF_STAT 8'h04
`define RSP_OFF_MASK 8'h08
`define RSP_OFF_TXD 8'h0c
`define RSP_OFF_RXD 8'h10
`define RSP_OFF_LDR_TXD 8'h14
`define RSP_OFF_LDR_RXD 8'h18
`define RSP_OFF_INFO 8'h1c
`define RSP_CTRL_RATE_LSB 0
`define RSP_CTRL_PAR_LSB 4
`define RSP_CTRL_STOP2_BIT 6
`define RSP_CTRL_WAIT_LSB 8
`define RSP_CTRL_REQ_OK_BIT 16
`define RSP_CTRL_REQ_BAD_BIT 17
`define RSP_CTRL_RESET 32'h0000_1442
`define RSP_WAIT_MIN_MS 5
`define RSP_WAIT_MAX_MS 99
`define RSP_WAIT_DEF_MS 20
`define RSP_ADDR_MAX 31
`define RSP_LED_PERIOD_MS 1000
`define RSP_LED_TIME_S 5
`define RSP_MS_CYCLES (`RSP_CLK_HZ / 1000)
`define RSP_LOADER_BAUD 9600
`define RSP_ST_RX 0
`define RSP_ST_TXDONE 1
`define RSP_ST_PERR 2
`define RSP_ST_FERR 3
`define RSP_ST_LDR_RX 4
`define RSP_ST_LDR_TXDONE 5
`endif

//--- hw/rsp_pkg.sv
package rsp_pkg;
  typedef enum logic [2:0] {
    RSP_B2400 = 3'h0, RSP_B4800 = 3'h1, RSP_B9600 = 3'h2, RSP_B19200 = 3'h3, RSP_B38400 = 3'h4
  } rsp_rate_type;
  typedef enum logic [1:0] {RSP_PAR_NONE = 2'h0, RSP_PAR_EVEN = 2'h1, RSP_PAR_ODD = 2'h2} rsp_par_type;
  typedef enum logic [2:0] {
    RSP_IDLE = 3'h0, RSP_START = 3'h1, RSP_DATA = 3'h3, RSP_PARITY = 3'h2, RSP_STOP = 3'h6
  } rsp_ser_type;
endpackage

//--- hw/rsp_uart_lane.sv
`timescale 1ns/1ps
`include "rsp_defines.svh"
module rsp_uart_lane (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [15:0] bit_div,
  input wire rsp_pkg::rsp_par_type par,
  input wire logic stop2,
  input wire logic tx_go,
  input wire logic [7:0] tx_byte,
  output logic tx_busy,
  output logic tx_done,
  output logic tx_line,
  input wire logic rx_line,
  output logic rx_valid,
  output logic [7:0] rx_byte,
  output logic rx_perr,
  output logic rx_ferr
);
  import rsp_pkg::*;
  rsp_ser_type tst_q, rst_q;
  logic [15:0] tcnt_q, rcnt_q;
  logic [3:0] tbit_q, rbit_q;
  logic [7:0] tsh_q, rsh_q;
  logic rpar_q;
  wire tick_t = (tcnt_q == 16'h0000);
  wire tx_par = ^tx_byte ^ (par == RSP_PAR_ODD); // R10
  always_ff @(posedge aclk) begin
    tx_done <= 1'b0;
    if (!aresetn) begin
      tst_q <= RSP_IDLE;
      tx_line <= 1'b1;
      tx_busy <= 1'b0;
      tcnt_q <= 16'h0000;
      tbit_q <= 4'h0;
      tsh_q <= 8'h00;
    end else if (tst_q == RSP_IDLE) begin
      tx_line <= 1'b1;
      if (tx_go) begin
        tst_q <= RSP_START;
        tx_busy <= 1'b1;
        tsh_q <= tx_byte;
        tx_line <= 1'b0; // R13
        tcnt_q <= bit_div;
        tbit_q <= 4'h0;
        tx_done <= 1'b0;
        if (par != RSP_PAR_NONE) begin
          tbit_q[3] <= tx_par;
        end
      end
    end else if (!tick_t) begin
      tcnt_q <= tcnt_q - 16'h0001;
    end else begin
      tcnt_q <= bit_div;
      case (tst_q)
        RSP_START: begin
          tst_q <= RSP_DATA;
          tx_line <= tsh_q[0]; // R13
          tsh_q <= {1'b0, tsh_q[7:1]};
          tbit_q[2:0] <= 3'h1;
        end
        RSP_DATA: begin
          if (tbit_q[2:0] == 3'h0) begin
            if (par != RSP_PAR_NONE) begin
              tst_q <= RSP_PARITY;
              tx_line <= tbit_q[3]; // R9
            end else begin
              tst_q <= RSP_STOP;
              tx_line <= 1'b1;
              tbit_q[2:0] <= {2'h0, stop2}; // R11
            end
          end else begin
            tx_line <= tsh_q[0];
            tsh_q <= {1'b0, tsh_q[7:1]};
            tbit_q[2:0] <= tbit_q[2:0] + 3'h1;
          end
        end
        RSP_PARITY: begin
          tst_q <= RSP_STOP;
          tx_line <= 1'b1;
          tbit_q[2:0] <= {2'h0, stop2}; // R11
        end
        default: begin
          if (tbit_q[2:0] == 3'h0) begin
            tst_q <= RSP_IDLE;
            tx_busy <= 1'b0;
            tx_done <= 1'b1;
          end else begin
            tbit_q[2:0] <= 3'h0;
          end
        end
      endcase
    end
  end
  wire tick_r = (rcnt_q == 16'h0000);
  always_ff @(posedge aclk) begin
    rx_valid <= 1'b0;
    if (!aresetn) begin
      rst_q <= RSP_IDLE;
      rcnt_q <= 16'h0000;
      rbit_q <= 4'h0;
      rsh_q <= 8'h00;
      rpar_q <= 1'b0;
      rx_byte <= 8'h00;
      rx_perr <= 1'b0;
      rx_ferr <= 1'b0;
    end else if (rst_q == RSP_IDLE) begin
      if (!rx_line) begin
        rst_q <= RSP_START;
        rcnt_q <= {1'b0, bit_div[15:1]};
      end
    end else if (!tick_r) begin
      rcnt_q <= rcnt_q - 16'h0001;
    end else begin
      rcnt_q <= bit_div;
      case (rst_q)
        RSP_START: begin
          if (rx_line) begin
            rst_q <= RSP_IDLE;
          end else begin
            rst_q <= RSP_DATA;
            rbit_q <= 4'h0;
          end
        end
        RSP_DATA: begin
          rsh_q <= {rx_line, rsh_q[7:1]}; // R13
          rbit_q <= rbit_q + 4'h1;
          if (rbit_q == 4'h7) begin
            rst_q <= (par != RSP_PAR_NONE) ? RSP_PARITY : RSP_STOP;
          end
        end
        RSP_PARITY: begin
          rpar_q <= rx_line;
          rst_q <= RSP_STOP;
        end
        default: begin
          rst_q <= RSP_IDLE;
          rx_valid <= 1'b1;
          rx_byte <= rsh_q;
          rx_ferr <= !rx_line;
          rx_perr <= (par != RSP_PAR_NONE) && ((^rsh_q ^ rpar_q) != (par == RSP_PAR_ODD)); // R9 R10
        end
      endcase
    end
  end
endmodule

//--- sim/rsp_master_model.sv
`timescale 1ns/1ps
// Master on the far side: one slave per address on this line
module rsp_master_model #(
  parameter int BIT = 2604
) (
  input wire logic aclk,
  input wire logic loader_tx,
  output logic line,
  output logic [7:0] ldr_byte
);
  initial line = 1'b1;
  initial ldr_byte = 8'h00;
  // One request character on the bus
  task automatic send(input logic [7:0] b, input int par, input int s2, input int bad);
    logic p;
    p = ^b ^ (par == 2) ^ (bad != 0);
    @(posedge aclk);
    line <= 1'b0;
    repeat (BIT) @(posedge aclk);
    for (int i = 0; i < 8; i++) begin
      line <= b[i];
      repeat (BIT) @(posedge aclk);
    end
    if (par != 0) begin
      line <= p;
      repeat (BIT) @(posedge aclk);
    end
    line <= 1'b1;
    repeat (s2 != 0 ? 2 * BIT : BIT) @(posedge aclk);
  endtask
  // Loader receiver at the fixed rate
  always begin
    @(negedge loader_tx);
    repeat (BIT / 2) @(posedge aclk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge aclk);
      ldr_byte[i] = loader_tx;
    end
  end
endmodule

//--- sim/rsp_serial_port_monitor.sv
`timescale 1ns/1ps
module rsp_serial_port_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] address_units_switch,
  input wire logic [1:0] address_group_switch,
  input wire logic rs485_tx,
  input wire logic rs485_de,
  input wire logic loader_tx,
  input wire logic [3:0] rate_led,
  input wire logic irq,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  localparam int BIT = 2604;
  logic [5:0] addr_w;
  logic [31:0] lt_q;
  assign addr_w = {2'h0, address_units_switch} + {address_group_switch, 4'h0};
  // Length of the current loader line level
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lt_q <= 32'h0;
    end else if ($changed(loader_tx)) begin
      lt_q <= 32'h1;
    end else begin
      lt_q <= lt_q + 32'h1;
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_bad_addr_quiet: assert property ((addr_w == 6'h0 || addr_w > 6'h1f) |-> !rs485_de && rs485_tx)
    else $error("bus driven with invalid address");
  chk_idle_line_high: assert property (!rs485_de |-> rs485_tx)
    else $error("line low without driver");
  chk_led_rate_only: assert property (rate_led == 4'h0 || rate_led == 4'h2)
    else $error("wrong rate indicator");
  chk_reset_outputs_idle: assert property ($rose(aresetn) |-> rs485_tx && loader_tx && !rs485_de && rate_led == 4'h0)
    else $error("outputs not idle after reset");
  chk_loader_bit_time: assert property ($rose(loader_tx) && lt_q != 32'h0 |-> lt_q % BIT == 0 && lt_q <= 9 * BIT)
    else $error("loader bit time wrong");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_read_resp_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer repeated");
  chk_write_resp_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer repeated");
  chk_write_ready_low: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("ready while answer pending");
  cover property ($rose(irq));
  cover property ($fell(irq));
  cover property ($rose(loader_tx) && lt_q != 32'h0);
endmodule
bind rsp_serial_port rsp_serial_port_monitor u_rsp_serial_port_monitor (.*);

//--- sim/tb_rsp_serial_port.sv
`timescale 1ns/1ps
`include "rsp_defines.svh"
module tb_rsp_serial_port;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [3:0] address_units_switch = 4'h0;
  logic [1:0] address_group_switch = 2'h0;
  logic rs485_rx, rs485_tx, rs485_de, loader_tx, irq;
  wire loader_rx = loader_tx;
  logic [3:0] rate_led;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0, ldr_byte, lb;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdv, seed = 32'hce46;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [7:0] q[$];
  int n_errors = 0, checks_done = 0, cycles = 0;
  always #20 aclk = ~aclk;
  rsp_serial_port u_rsp_serial_port (.*);
  rsp_master_model u_rsp_master_model (.aclk(aclk), .loader_tx(loader_tx), .line(rs485_rx), .ldr_byte(ldr_byte));
  function automatic logic [7:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic stop_test();
    if (n_errors == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 95000) begin
      n_errors++;
      stop_test();
    end
  end
  task automatic rst(input int u, input int g);
    @(posedge aclk);
    aresetn <= 1'b0;
    address_units_switch <= u[3:0];
    address_group_switch <= g[1:0];
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk("bresp", s_axi_bresp, er);
  endtask
  task automatic rd(input logic [7:0] a, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    rdv = s_axi_rdata;
    chk("rresp", s_axi_rresp, er);
  endtask
  task automatic frame(input int par, input int s2, input int bad);
    logic [7:0] b;
    b = xs();
    if (bad == 0) q.push_back(b);
    u_rsp_master_model.send(b, par, s2, bad);
    for (int n = 0; n < 5000 && irq !== 1'b1; n++) @(posedge aclk);
    chk("irq", irq, 1);
  endtask
  initial begin
    int tu[5] = '{0, 5, 15, 1, 1};
    int tg[5] = '{0, 1, 1, 2, 0};
    int a;
    for (int i = 0; i < 5; i++) begin
      rst(tu[i], tg[i]);
      a = tu[i] + 16 * tg[i];
      rd(`RSP_OFF_INFO, 2'h0);
      chk("addr", rdv[4:0], a[4:0]);
      chk("addr_ok", rdv[10], a >= 1 && a <= 31);
      chk("rate", rdv[9:7], 2);
      chk("led", rate_led, 4'h2);
    end
    rd(`RSP_OFF_CTRL, 2'h0);
    chk("ctrl", rdv, 32'h1442);
    wr(`RSP_OFF_CTRL, 32'h1444, 2'h0);
    rd(`RSP_OFF_INFO, 2'h0);
    chk("rate_kept", rdv[9:7], 2);
    wr(8'h02, 32'h0, 2'h2);
    rd(8'h20, 2'h2);
    chk("unmapped", rdv, 32'h0);
    wr(`RSP_OFF_CTRL, 32'h11442, 2'h0);
    wr(`RSP_OFF_TXD, 32'h55, 2'h0);
    rd(`RSP_OFF_TXD, 2'h0);
    chk("reply_gate", rdv[9:8], 0);
    chk("txd_drop", rdv[7:0], 0);
    wr(`RSP_OFF_MASK, 32'h25, 2'h0);
    wr(`RSP_OFF_STAT, 32'h3f, 2'h0);
    lb = xs();
    wr(`RSP_OFF_LDR_TXD, {24'h0, lb}, 2'h0);
    frame(0, 1, 0);
    rd(`RSP_OFF_STAT, 2'h0);
    chk("stat_a", rdv & 32'h35, 32'h31);
    rd(`RSP_OFF_RXD, 2'h0);
    chk("rxd_a", rdv[7:0], q.pop_front());
    chk("loader", ldr_byte, lb);
    rd(`RSP_OFF_LDR_RXD, 2'h0);
    chk("ldr_rxd", rdv[7:0], lb);
    wr(`RSP_OFF_STAT, 32'h3f, 2'h0);
    repeat (2) @(posedge aclk);
    chk("irq_clr", irq, 0);
    wr(`RSP_OFF_MASK, 32'h01, 2'h0);
    wr(`RSP_OFF_CTRL, 32'h1412, 2'h0);
    frame(1, 0, 0);
    rd(`RSP_OFF_STAT, 2'h0);
    chk("stat_b", rdv & 32'h0f, 32'h01);
    rd(`RSP_OFF_RXD, 2'h0);
    chk("rxd_b", rdv[7:0], q.pop_front());
    wr(`RSP_OFF_STAT, 32'h3f, 2'h0);
    wr(`RSP_OFF_MASK, 32'h04, 2'h0);
    wr(`RSP_OFF_CTRL, 32'h21422, 2'h0);
    frame(2, 0, 1);
    rd(`RSP_OFF_STAT, 2'h0);
    chk("perr", rdv[2], 1);
    wr(`RSP_OFF_CTRL, 32'h11422, 2'h0);
    rd(`RSP_OFF_INFO, 2'h0);
    chk("no_reply", rdv[11], 0);
    wr(`RSP_OFF_MASK, 32'h0, 2'h0);
    repeat (2) @(posedge aclk);
    chk("irq_mask", irq, 0);
    stop_test();
  end
endmodule
